//--- logic/lane_irq_ctrl.sv
// Lane 7 status, alignment checks and paged interrupt enables for the links
// ****************************************************************
// What this block does
// [R1] Lane 7 bad-symbol flag is 1 when its count reaches the error limit.
// [R2] Lane 7 stray control flag is 1 when its count reaches the limit.
// [R3] Bit 4 shows deskew succeeded (1) or failed (0).
// [R4] Bit 3 shows initial lane sync achieved (1) or lost (0).
// [R5] Bit 2 shows the computed checksum correct (1) or wrong (0).
// [R6] Bit 1 shows frame sync achieved (1) or lost (0).
// [R7] Bit 0 shows code group sync; all status bits read-only, reset zero.
// [R8] Status and enable bits are banked per link, chosen by page register.
// [R9] Enable register A holds eight read/write enables, reset to zero.
// [R10] Checksum judged from transmitted checksum against sum of received data.
// [R11] Checksum judgement ignores the programmed expected checksum.
// [R12] Lane 0 flags mismatch if any received config differs from programmed.
// [R13] Link interrupt fires only for enabled events.
// ****************************************************************
`timescale 1ns/1ns
module lane_irq_ctrl (
   input wire logic I_MCLK, // 125 MHz clock
   input wire logic I_RST, // Sync reset, high
   input wire logic I_REG_WR, // Register write strobe
   input wire logic I_REG_RD, // Register read strobe
   input wire logic [lane_irq_pkg::ADDR_W-1:0] I_REG_ADDR, // Register address
   input wire logic [lane_irq_pkg::DATA_W-1:0] I_REG_WDATA, // Write data
   output logic [lane_irq_pkg::DATA_W-1:0] O_REG_RDATA, // Read data
   output logic O_REG_RVALID, // Read data valid
   input wire lane_irq_pkg::lane_state_t [lane_irq_pkg::NLINK-1:0] I_LANE7_STATE,  // Lane 7
   input wire lane_irq_pkg::ilas_octet_t [lane_irq_pkg::NLINK-1:0] I_LANE7_ILAS,   // Lane 7
   input wire lane_irq_pkg::ilas_octet_t [lane_irq_pkg::NLINK-1:0] I_LANE0_ILAS,   // Lane 0
   input wire logic [lane_irq_pkg::NLINK-1:0][lane_irq_pkg::DATA_W-1:0] I_ERROR_LIMIT, // Limit
   output logic [lane_irq_pkg::NLINK-1:0] O_LINK_IRQ // Interrupt pulse per link
);

   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [lane_irq_pkg::PAGE_W-1:0] link_page;
   logic [lane_irq_pkg::DATA_W-1:0] link_irq_enable_a [lane_irq_pkg::NLINK];
   logic irq_mask_config_mismatch [lane_irq_pkg::NLINK];
   logic [lane_irq_pkg::DATA_W-1:0] cfg_mem [lane_irq_pkg::NLINK][lane_irq_pkg::ILAS_LEN];

   // Per-link derived state
   logic [lane_irq_pkg::DATA_W-1:0] lane7_link_status [lane_irq_pkg::NLINK];
   logic [lane_irq_pkg::DATA_W-1:0] prev_status [lane_irq_pkg::NLINK];
   logic [lane_irq_pkg::NLINK-1:0] checksum_ok;
   logic [lane_irq_pkg::NLINK-1:0] mismatch;
   logic [lane_irq_pkg::NLINK-1:0] next_irq;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   wire hit_page = (I_REG_ADDR == lane_irq_pkg::ADDR_LINK_PAGE);
   wire hit_status = (I_REG_ADDR == lane_irq_pkg::ADDR_LANE7_STATUS);
   wire hit_en_a = (I_REG_ADDR == lane_irq_pkg::ADDR_IRQ_EN_A);
   wire hit_en_b = (I_REG_ADDR == lane_irq_pkg::ADDR_IRQ_EN_B);
   wire hit_cfg = (I_REG_ADDR >= lane_irq_pkg::ADDR_CFG_FIRST)
                  && (I_REG_ADDR <= lane_irq_pkg::ADDR_CFG_LAST);
   wire [lane_irq_pkg::ADDR_W-1:0] cfg_off = I_REG_ADDR - lane_irq_pkg::ADDR_CFG_FIRST;
   wire [lane_irq_pkg::ILAS_IDX_W-1:0] cfg_idx = cfg_off[lane_irq_pkg::ILAS_IDX_W-1:0];

   wire wr_page = I_REG_WR && hit_page;
   wire wr_en_a = I_REG_WR && hit_en_a;
   wire wr_en_b = I_REG_WR && hit_en_b;
   wire wr_cfg = I_REG_WR && hit_cfg;
   // Status register is read-only: writes to it fall through untouched

   // ****************************************************************
   // Read selection, banked registers from the selected bank
   // ****************************************************************
   wire [lane_irq_pkg::DATA_W-1:0] rd_page =
      {{(lane_irq_pkg::DATA_W-lane_irq_pkg::PAGE_W){1'b0}}, link_page};
   wire [lane_irq_pkg::DATA_W-1:0] rd_status = lane7_link_status[link_page]; // [R8]
   wire [lane_irq_pkg::DATA_W-1:0] rd_en_a = link_irq_enable_a[link_page]; // [R8]
   // Upper bits of enable B are reserved and read as zero
   wire [lane_irq_pkg::DATA_W-1:0] rd_en_b =
      {{(lane_irq_pkg::DATA_W-1){1'b0}}, irq_mask_config_mismatch[link_page]};
   wire [lane_irq_pkg::DATA_W-1:0] rd_cfg = cfg_mem[link_page][cfg_idx];

   wire [lane_irq_pkg::DATA_W-1:0] rd_mux =
      hit_page   ? rd_page :
      hit_status ? rd_status :
      hit_en_a   ? rd_en_a :
      hit_en_b   ? rd_en_b :
      hit_cfg    ? rd_cfg :
      lane_irq_pkg::READ_ZERO;

   // ****************************************************************
   // Page and read-back registers
   // ****************************************************************
   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         link_page <= lane_irq_pkg::RST_PAGE;
      end else if (wr_page) begin
         link_page <= I_REG_WDATA[lane_irq_pkg::PAGE_W-1:0]; // [R8]
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         O_REG_RDATA <= lane_irq_pkg::READ_ZERO;
         O_REG_RVALID <= 1'b0;
      end else begin
         O_REG_RVALID <= I_REG_RD;
         O_REG_RDATA <= I_REG_RD ? rd_mux : lane_irq_pkg::READ_ZERO;
      end
   end

   // ****************************************************************
   // Per-link banks, checks and interrupt
   // ****************************************************************
   genvar l;
   generate
      for (l = 0; l < lane_irq_pkg::NLINK; l++) begin : g_link
         wire sel = (link_page == (lane_irq_pkg::PAGE_W)'(l));
         lane_irq_pkg::cfg_bytes_t expected;
         logic [lane_irq_pkg::DATA_W-1:0] ev_a;
         logic cksum_done;
         logic cksum_bad;

         for (genvar k = 0; k < lane_irq_pkg::ILAS_LEN; k++) begin : g_cfg
            assign expected[k] = cfg_mem[l][k];
            wire wr_here = wr_cfg && sel
                           && (cfg_idx == (lane_irq_pkg::ILAS_IDX_W)'(k));
            always_ff @(posedge I_MCLK) begin
               if (I_RST) begin
                  cfg_mem[l][k] <= lane_irq_pkg::RST_CFG;
               end else if (wr_here) begin
                  cfg_mem[l][k] <= I_REG_WDATA; // [R8]
               end
            end
         end

         always_ff @(posedge I_MCLK) begin
            if (I_RST) begin
               link_irq_enable_a[l] <= lane_irq_pkg::RST_IRQ_EN; // [R9]
               irq_mask_config_mismatch[l] <= 1'b0;
            end else begin
               if (wr_en_a && sel) begin
                  link_irq_enable_a[l] <= I_REG_WDATA; // [R9] [R8]
               end
               if (wr_en_b && sel) begin
                  irq_mask_config_mismatch[l] <=
                     I_REG_WDATA[lane_irq_pkg::BIT_CFG_MISMATCH]; // [R8]
               end
            end
         end

         // Lane 7 judges its own checksum only; expected compare is off
         ilas_checker u_lane7_check (
            .i_clk(I_MCLK),
            .i_rst(I_RST),
            .i_ilas(I_LANE7_ILAS[l]),
            .i_expected(expected),
            .i_compare_en(1'b0), // [R11]
            .o_checksum_ok(checksum_ok[l]),
            .o_done(cksum_done),
            .o_mismatch()
         );

         // Lane 0 is the only lane checked against programmed config
         ilas_checker u_lane0_check (
            .i_clk(I_MCLK),
            .i_rst(I_RST),
            .i_ilas(I_LANE0_ILAS[l]),
            .i_expected(expected),
            .i_compare_en(1'b1), // [R12]
            .o_checksum_ok(),
            .o_done(),
            .o_mismatch(mismatch[l])
         );

         lane_status_flags u_flags (
            .i_clk(I_MCLK),
            .i_rst(I_RST),
            .i_state(I_LANE7_STATE[l]),
            .i_limit(I_ERROR_LIMIT[l]),
            .i_checksum_ok(checksum_ok[l]),
            .o_status(lane7_link_status[l])
         );

         always_ff @(posedge I_MCLK) begin
            if (I_RST) begin
               prev_status[l] <= lane_irq_pkg::RST_STATUS;
            end else begin
               prev_status[l] <= lane7_link_status[l];
            end
         end

         // Error flags fire on crossing the limit, sync flags on loss
         assign cksum_bad = cksum_done && !checksum_ok[l];
         always_comb begin
            ev_a = (lane7_link_status[l] & ~prev_status[l] & lane_irq_pkg::RISE_EVENTS)
                   | (~lane7_link_status[l] & prev_status[l] & ~lane_irq_pkg::RISE_EVENTS);
            // Checksum judged per sequence, so a repeated bad result fires again
            ev_a[lane_irq_pkg::BIT_CHECKSUM] = cksum_bad; // [R10]
         end

         // Masked events never reach the pin
         assign next_irq[l] = (|(ev_a & link_irq_enable_a[l]))
                              | (mismatch[l] & irq_mask_config_mismatch[l]); // [R13]
      end
   endgenerate

   always_ff @(posedge I_MCLK) begin
      if (I_RST) begin
         O_LINK_IRQ <= '0;
      end else begin
         O_LINK_IRQ <= next_irq; // [R13]
      end
   end

endmodule

//--- common/lane_irq_pkg.sv
// Shared constants, register map and carrier types of the lane status block
package lane_irq_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NLINK = 2;
   localparam int PAGE_W = 1;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int ILAS_LEN = 14;
   localparam int ILAS_IDX_W = 4;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_LINK_PAGE = 12'h300;
   localparam logic [ADDR_W-1:0] ADDR_CFG_FIRST = 12'h450;
   localparam logic [ADDR_W-1:0] ADDR_CFG_LAST = 12'h45d;
   localparam logic [ADDR_W-1:0] ADDR_LANE7_STATUS = 12'h4b7;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN_A = 12'h4b8;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN_B = 12'h4b9;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
   localparam logic [DATA_W-1:0] RST_IRQ_EN = 8'h00;
   localparam logic [DATA_W-1:0] RST_CFG = 8'h00;
   localparam logic [PAGE_W-1:0] RST_PAGE = 1'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

   // ****************************************************************
   // Field positions of lane7_link_status and link_irq_enable_a
   // ****************************************************************
   localparam int BIT_DISPARITY = 7;
   localparam int BIT_BAD_SYMBOL = 6;
   localparam int BIT_STRAY_CTRL = 5;
   localparam int BIT_DESKEW = 4;
   localparam int BIT_INIT_SYNC = 3;
   localparam int BIT_CHECKSUM = 2;
   localparam int BIT_FRAME_SYNC = 1;
   localparam int BIT_CG_SYNC = 0;
   // link_irq_enable_b
   localparam int BIT_CFG_MISMATCH = 0;

   // Event polarity: error flags fire on rise, sync flags on fall
   localparam logic [DATA_W-1:0] RISE_EVENTS = 8'he0;

   // Octet position of the transmitted checksum in the alignment data
   localparam logic [ILAS_IDX_W-1:0] CKSUM_IDX = 4'hd;
   localparam logic [ILAS_IDX_W-1:0] FIRST_IDX = 4'h0;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic [DATA_W-1:0] disparity_errs;
      logic [DATA_W-1:0] bad_symbol_errs;
      logic [DATA_W-1:0] stray_ctrl_errs;
      logic deskew_ok;
      logic init_sync_ok;
      logic frame_sync_ok;
      logic codegroup_sync_ok;
   } lane_state_t;

   typedef struct packed {
      logic valid;
      logic [ILAS_IDX_W-1:0] idx;
      logic [DATA_W-1:0] octet;
   } ilas_octet_t;

   typedef logic [ILAS_LEN-1:0][DATA_W-1:0] cfg_bytes_t;

endpackage

//--- logic/lane_status_flags.sv
// Builds one link's lane 7 status byte from counts, limit and sync levels
`timescale 1ns/1ns
module lane_status_flags (
   input wire logic i_clk, // System clock
   input wire logic i_rst, // Synchronous reset
   input wire lane_irq_pkg::lane_state_t i_state, // Lane 7 receiver state
   input wire logic [lane_irq_pkg::DATA_W-1:0] i_limit, // Error threshold
   input wire logic i_checksum_ok, // Checksum judgement
   output logic [lane_irq_pkg::DATA_W-1:0] o_status // Status byte
);

   logic [lane_irq_pkg::DATA_W-1:0] next_status;

   // ****************************************************************
   // Flag assembly
   // ****************************************************************
   always_comb begin
      next_status = lane_irq_pkg::RST_STATUS;
      next_status[lane_irq_pkg::BIT_DISPARITY] = (i_state.disparity_errs >= i_limit);
      next_status[lane_irq_pkg::BIT_BAD_SYMBOL] = (i_state.bad_symbol_errs >= i_limit); // [R1]
      next_status[lane_irq_pkg::BIT_STRAY_CTRL] = (i_state.stray_ctrl_errs >= i_limit); // [R2]
      next_status[lane_irq_pkg::BIT_DESKEW] = i_state.deskew_ok; // [R3]
      next_status[lane_irq_pkg::BIT_INIT_SYNC] = i_state.init_sync_ok; // [R4]
      next_status[lane_irq_pkg::BIT_CHECKSUM] = i_checksum_ok; // [R5]
      next_status[lane_irq_pkg::BIT_FRAME_SYNC] = i_state.frame_sync_ok; // [R6]
      next_status[lane_irq_pkg::BIT_CG_SYNC] = i_state.codegroup_sync_ok; // [R7]
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_status <= lane_irq_pkg::RST_STATUS; // [R7]
      end else begin
         o_status <= next_status;
      end
   end

endmodule

//--- logic/ilas_checker.sv
// Judges one lane's alignment data: own checksum and optional expected compare
`timescale 1ns/1ns
module ilas_checker (
   input wire logic i_clk, // System clock
   input wire logic i_rst, // Synchronous reset
   input wire lane_irq_pkg::ilas_octet_t i_ilas, // Received octet
   input wire lane_irq_pkg::cfg_bytes_t i_expected, // Programmed config
   input wire logic i_compare_en, // Enable expected compare
   output logic o_checksum_ok, // Level, last result
   output logic o_done, // Pulse, sequence ended
   output logic o_mismatch // Pulse, config differs
);

   logic [lane_irq_pkg::DATA_W-1:0] sum;
   logic differs;
   wire is_first = i_ilas.valid && (i_ilas.idx == lane_irq_pkg::FIRST_IDX);
   wire is_cksum = i_ilas.valid && (i_ilas.idx == lane_irq_pkg::CKSUM_IDX);
   wire [lane_irq_pkg::DATA_W-1:0] base = is_first ? lane_irq_pkg::READ_ZERO : sum;
   wire octet_differs = i_compare_en && (i_ilas.octet != i_expected[i_ilas.idx]);
   wire diff_so_far = (is_first ? 1'b0 : differs) | octet_differs;
   // Only transmitted octets feed the sum; the programmed checksum never does
   wire cksum_good = (base == i_ilas.octet); // [R10] [R11]

   // ****************************************************************
   // Accumulate and judge
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sum <= lane_irq_pkg::READ_ZERO;
         differs <= 1'b0;
         o_checksum_ok <= 1'b0;
         o_done <= 1'b0;
         o_mismatch <= 1'b0;
      end else begin
         o_done <= is_cksum;
         o_mismatch <= is_cksum && diff_so_far; // [R12]
         if (i_ilas.valid && !is_cksum) begin
            sum <= base + i_ilas.octet;
            differs <= diff_so_far;
         end
         if (is_cksum) begin
            o_checksum_ok <= cksum_good; // [R10]
         end
      end
   end

endmodule

//--- verification/lane_irq_ctrl_assertions.sv
// Concurrent checks on the lane status and interrupt enable block
`timescale 1ns/1ns
module lane_irq_ctrl_assertions (
   input wire logic I_MCLK, // Clock
   input wire logic I_RST, // Sync reset
   input wire logic I_REG_WR, // Write strobe
   input wire logic I_REG_RD, // Read strobe
   input wire logic [lane_irq_pkg::ADDR_W-1:0] I_REG_ADDR, // Address
   input wire logic [lane_irq_pkg::DATA_W-1:0] I_REG_WDATA, // Write data
   input wire logic [lane_irq_pkg::DATA_W-1:0] O_REG_RDATA, // Read data
   input wire logic O_REG_RVALID, // Read valid
   input wire lane_irq_pkg::lane_state_t [lane_irq_pkg::NLINK-1:0] I_LANE7_STATE, // State
   input wire lane_irq_pkg::ilas_octet_t [lane_irq_pkg::NLINK-1:0] I_LANE7_ILAS,  // Lane 7
   input wire lane_irq_pkg::ilas_octet_t [lane_irq_pkg::NLINK-1:0] I_LANE0_ILAS,  // Lane 0
   input wire logic [lane_irq_pkg::NLINK-1:0][lane_irq_pkg::DATA_W-1:0] I_ERROR_LIMIT, // Limit
   input wire logic [lane_irq_pkg::NLINK-1:0] O_LINK_IRQ // Interrupts
);
   // ****
   // Shadow of page, enables and link 0 checksum
   // ****
   logic pg;
   logic pg_d;
   logic [7:0] en_a [2];
   logic [1:0] en_b;
   logic [7:0] sum;
   logic [71:0] inp;
   logic [1:0] en_any;
   logic [7:0] cur_en;
   logic [7:0] exp_st;
   logic cks_end;
   logic cks_bad;
   lane_irq_pkg::lane_state_t s;
   logic [7:0] l;
   assign inp = {I_LANE7_STATE, I_ERROR_LIMIT};
   assign en_any = {en_a[1] != 8'h00 || en_b[1], en_a[0] != 8'h00 || en_b[0]};
   assign cur_en = en_a[pg];
   assign s = I_LANE7_STATE[pg_d];
   assign l = I_ERROR_LIMIT[pg_d];
   assign exp_st = {s.disparity_errs >= l, s.bad_symbol_errs >= l, s.stray_ctrl_errs >= l,
      s.deskew_ok, s.init_sync_ok, 1'b0, s.frame_sync_ok, s.codegroup_sync_ok};
   assign cks_end = I_LANE7_ILAS[0].valid && I_LANE7_ILAS[0].idx == lane_irq_pkg::CKSUM_IDX;
   assign cks_bad = cks_end && I_LANE7_ILAS[0].octet != sum;
   always_ff @(posedge I_MCLK) begin
      pg_d <= I_RST ? 1'b0 : pg;
      if (I_RST) begin
         pg <= 1'b0;
         en_a <= '{8'h00, 8'h00};
         en_b <= 2'b00;
      end else if (I_REG_WR) begin
         if (I_REG_ADDR == lane_irq_pkg::ADDR_LINK_PAGE) pg <= I_REG_WDATA[0];
         if (I_REG_ADDR == lane_irq_pkg::ADDR_IRQ_EN_A) en_a[pg] <= I_REG_WDATA;
         if (I_REG_ADDR == lane_irq_pkg::ADDR_IRQ_EN_B) en_b[pg] <= I_REG_WDATA[0];
      end
      if (I_LANE7_ILAS[0].valid) begin
         sum <= (I_LANE7_ILAS[0].idx == lane_irq_pkg::FIRST_IDX) ? I_LANE7_ILAS[0].octet :
            sum + I_LANE7_ILAS[0].octet;
      end
   end
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RST);
   // Read of the status byte with quiet inputs around it
   sequence rd_stat;
      $stable(inp) ##1 I_REG_RD && I_REG_ADDR == lane_irq_pkg::ADDR_LANE7_STATUS && $stable(inp)
         ##1 $stable(inp);
   endsequence
   a_rvalid_after_rd: assert property (I_REG_RD |=> O_REG_RVALID)
      else $error("read not answered");
   a_rvalid_cause: assert property (O_REG_RVALID |-> $past(I_REG_RD))
      else $error("read valid without read");
   a_rdata_idle: assert property (!O_REG_RVALID |-> O_REG_RDATA == 8'h00)
      else $error("read data not zero when idle");
   a_error_flags: assert property (rd_stat |-> O_REG_RDATA[7:5] == exp_st[7:5])
      else $error("error flags wrong");
   a_sync_flags: assert property (rd_stat |-> {O_REG_RDATA[4:3], O_REG_RDATA[1:0]} ==
      {exp_st[4:3], exp_st[1:0]}) else $error("sync flags wrong");
   a_enable_readback: assert property (I_REG_RD && I_REG_ADDR == lane_irq_pkg::ADDR_IRQ_EN_A
      |=> O_REG_RDATA == $past(cur_en)) else $error("enable readback wrong");
   a_irq_masked: assert property ((O_LINK_IRQ & ~$past(en_any) & ~$past(en_any, 2)) == 2'b00)
      else $error("interrupt with no enable");
   a_deskew_irq: assert property ($fell(I_LANE7_STATE[0].deskew_ok) && en_a[0][4]
      |-> ##2 O_LINK_IRQ[0]) else $error("deskew loss not signalled");
   a_cks_bad_irq: assert property (cks_bad && en_a[0][2] |-> ##2 O_LINK_IRQ[0])
      else $error("bad checksum not signalled");
   a_cks_good_quiet: assert property (cks_end && !cks_bad && en_a[0] == 8'h04 && !en_b[0]
      |-> ##2 !O_LINK_IRQ[0]) else $error("good checksum signalled");
   c_status_read: cover property (rd_stat);
   c_irq_link0: cover property (O_LINK_IRQ[0]);
   c_cks_bad: cover property (cks_bad);
endmodule
bind lane_irq_ctrl lane_irq_ctrl_assertions chk (.I_MCLK, .I_RST, .I_REG_WR, .I_REG_RD,
   .I_REG_ADDR, .I_REG_WDATA, .O_REG_RDATA, .O_REG_RVALID, .I_LANE7_STATE, .I_LANE7_ILAS,
   .I_LANE0_ILAS, .I_ERROR_LIMIT, .O_LINK_IRQ);

//--- verification/lane_tx_model.sv
// Transmitter model sending one alignment sequence on a lane
`timescale 1ns/1ns
module lane_tx_model (
   input wire logic i_clk, // Clock
   input wire logic i_go, // Start a sequence
   input wire logic i_bad, // Corrupt the sent checksum
   input wire logic i_slow, // Idle cycle after each octet
   input wire logic [7:0] i_base, // First octet value
   output lane_irq_pkg::ilas_octet_t o_ilas, // Octet stream
   output logic o_busy // Sequence running
);
   logic [7:0] sum;
   logic [7:0] oct;
   initial begin
      o_ilas = '0;
      o_busy = 1'b0;
   end
   always @(posedge i_clk) begin
      if (i_go && !o_busy) begin
         o_busy <= 1'b1;
         sum = 8'h00;
         for (int k = 0; k < 14; k++) begin
            oct = (k == 13) ? sum + {7'h00, i_bad} : i_base + 8'(k * 5);
            sum = sum + oct;
            o_ilas <= '{valid: 1'b1, idx: 4'(k), octet: oct};
            @(posedge i_clk);
            // Idle cycles carry the inverted last octet and index, after each octet of a slow sequence
            if (i_slow) begin
               o_ilas <= '{valid: 1'b0, idx: ~o_ilas.idx, octet: ~o_ilas.octet};
               @(posedge i_clk);
            end
         end
         o_ilas <= '{valid: 1'b0, idx: ~o_ilas.idx, octet: ~o_ilas.octet};
         o_busy <= 1'b0;
      end
   end
endmodule

//--- verification/jesd_lane_status_irq_enable_test.sv
// Self-checking bench of the lane status and interrupt enable block
`timescale 1ns/1ns
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module jesd_lane_status_irq_enable_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic rvalid;
   lane_irq_pkg::lane_state_t [1:0] st = '0;
   lane_irq_pkg::lane_state_t ok, ns;
   logic [1:0][7:0] lim = {8'h10, 8'h10};
   lane_irq_pkg::ilas_octet_t t7, t0;
   logic [1:0] irq, irq_seen = 2'b00;
   logic go7 = 1'b0, go0 = 1'b0, bad = 1'b0, slow = 1'b0, busy7, busy0;
   logic [7:0] base = 8'h21, nl, s, o;
   logic pg = 1'b0, ck_ok = 1'b0;
   logic [7:0] en_a [2] = '{8'h00, 8'h00};
   logic [7:0] en_b [2] = '{8'h00, 8'h00};
   logic [7:0] cfg [2][14] = '{default: 8'h00};
   logic [11:0] alist [6] = '{12'h300, 12'h4b7, 12'h4b8, 12'h4b9, 12'h45d, 12'h123};
   int fail_count = 0, n_checks = 0, cyc = 0, seed = 89390;
   lane_irq_ctrl uut (.I_MCLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
      .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_LANE7_STATE(st),
      .I_LANE7_ILAS({t7, t7}), .I_LANE0_ILAS({t0, t0}), .I_ERROR_LIMIT(lim), .O_LINK_IRQ(irq));
   lane_tx_model tx7 (.i_clk(clk), .i_go(go7), .i_bad(bad), .i_slow(slow), .i_base(base),
      .o_ilas(t7), .o_busy(busy7));
   lane_tx_model tx0 (.i_clk(clk), .i_go(go0), .i_bad(bad), .i_slow(slow), .i_base(base),
      .o_ilas(t0), .o_busy(busy0));
   always #4 clk = ~clk;
   always @(posedge clk) irq_seen <= irq_seen | irq;
   // Hang guard, far above the several hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   // ****
   // Reference model
   // ****
   function automatic logic [7:0] exp_rd(input logic [11:0] a);
      int l;
      l = lim[pg];
      if (a == lane_irq_pkg::ADDR_LINK_PAGE) return {7'h00, pg};
      if (a == lane_irq_pkg::ADDR_IRQ_EN_A) return en_a[pg];
      if (a == lane_irq_pkg::ADDR_IRQ_EN_B) return en_b[pg];
      if (a >= 12'h450 && a <= 12'h45d) return cfg[pg][a - 12'h450];
      if (a != lane_irq_pkg::ADDR_LANE7_STATUS) return 8'h00;
      return {st[pg].disparity_errs >= l, st[pg].bad_symbol_errs >= l, st[pg].stray_ctrl_errs >= l,
         st[pg].deskew_ok, st[pg].init_sync_ok, ck_ok, st[pg].frame_sync_ok, st[pg].codegroup_sync_ok};
   endfunction
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      if (a == 12'h300) pg = d[0];
      else if (a == 12'h4b8) en_a[pg] = d;
      else if (a == 12'h4b9) en_b[pg] = {7'h00, d[0]};
      else if (a >= 12'h450 && a <= 12'h45d) cfg[pg][a - 12'h450] = d;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      logic [7:0] e;
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      e = exp_rd(a);
      @(negedge clk);
      `CHK(rvalid, 1'b1, "read not answered")
      `CHK(rdata, e, "read data")
   endtask
   task automatic send(input logic lane7, input logic b);
      int i;
      bad = b;
      @(posedge clk);
      if (lane7) go7 <= 1'b1;
      else go0 <= 1'b1;
      @(posedge clk);
      go7 <= 1'b0;
      go0 <= 1'b0;
      i = 0;
      do @(negedge clk); while ((busy7 || busy0) && i++ < 80);
      `CHK(i <= 80, 1'b1, "sequence never ended")
      if (lane7) ck_ok = !b;
      repeat (4) @(posedge clk);
   endtask
   task automatic clr_irq;
      @(negedge clk);
      irq_seen = 2'b00;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         wr_reg(12'h300, {7'h00, k[0]});
         foreach (alist[j]) rd_reg(alist[j]);
      end
      $display("test reset values done");
      for (int k = 0; k < 4; k++) begin
         wr_reg(12'h300, {7'($random(seed)), k[0]});
         wr_reg(12'h4b8, 8'($random(seed)));
         wr_reg(12'h4b9, 8'($random(seed)));
         wr_reg(12'h4b7, 8'hff);
         wr_reg(12'h45d, 8'($random(seed)));
         foreach (alist[j]) rd_reg(alist[j]);
         wr_reg(12'h4b8, 8'h00);
         wr_reg(12'h4b9, 8'h00);
      end
      $display("test registers done");
      repeat (30) begin
         nl = 8'($random(seed));
         ns = 28'($random(seed));
         ns.bad_symbol_errs = nl - 8'(ns[0]);
         ns.stray_ctrl_errs = nl - 8'(ns[1]);
         @(posedge clk);
         st[ns[2]] <= ns;
         lim[ns[2]] <= nl;
         wr_reg(12'h300, {7'h00, ns[2]});
         rd_reg(12'h4b7);
      end
      $display("test status done");
      ok = {8'h00, 8'h00, 8'h00, 4'hf};
      wr_reg(12'h300, 8'h00);
      for (int b = 0; b < 8; b++) begin
         if (b == 2) continue;
         @(posedge clk);
         st <= {ok, ok};
         lim <= {8'h10, 8'h10};
         wr_reg(12'h4b8, 8'h01 << b);
         ns = ok;
         if (b >= 5) ns[4 + 8 * (b - 5) +: 8] = 8'h10;
         else ns[b > 2 ? b - 1 : b] = 1'b0;
         clr_irq();
         @(posedge clk);
         st <= {ns, ns};
         repeat (4) @(posedge clk);
         @(negedge clk);
         `CHK(irq_seen, 2'b01, "event interrupt")
      end
      @(posedge clk);
      st <= {ok, ok};
      $display("test interrupt enables done");
      for (int p = 0; p < 2; p++) begin
         wr_reg(12'h300, 8'(p));
         wr_reg(12'h4b8, 8'h04);
         wr_reg(12'h45d, 8'h5a);
      end
      for (int j = 0; j < 4; j++) begin
         slow = j[0];
         clr_irq();
         send(1'b1, j[1]);
         `CHK(irq_seen, {2{j[1]}}, "checksum interrupt")
         rd_reg(12'h4b7);
      end
      $display("test checksum done");
      for (int p = 0; p < 2; p++) begin
         wr_reg(12'h300, 8'(p));
         wr_reg(12'h4b8, 8'h00);
         wr_reg(12'h4b9, 8'h01);
         s = 8'h00;
         for (int k = 0; k < 14; k++) begin
            o = (k == 13) ? s : base + 8'(k * 5);
            s = s + o;
            wr_reg(12'h450 + 12'(k), o + 8'(p == 1 && k == 13));
         end
      end
      clr_irq();
      send(1'b0, 1'b0);
      `CHK(irq_seen, 2'b10, "config mismatch interrupt")
      $display("test config mismatch done");
      finish_test();
   end
endmodule
